// >>> pkg/vcc_pkg.sv
// Functional notes
// (RULE1) command filter time constant 0..65535 x 0.01 ms, default 40, live
// (RULE2) larger time constant smooths more and responds proportionally slower
// (RULE3) clamp input on and command below level: zero command, hold position
// (RULE4) command above clamp level releases clamp even with input still on
// (RULE5) clamp input off never clamps, whatever the command
// (RULE6) clamp acts only in velocity or internal velocity control modes
// (RULE7) rotary clamp level 0..10000 rpm, default 10, live
// (RULE8) linear clamp level 0..10000 mm/s, default 10, live
// (RULE9) effective clamp level limited to the motor maximum velocity
// (RULE10) reach output on when motor speed matches the command
// (RULE11) reach output off while speed has not reached the command
// (RULE12) reached means within plus or minus band, both ends inclusive
// (RULE13) rotary reach band 0..100 rpm, default 10, live
// (RULE14) linear reach band 0..100 mm/s, default 10, live
// (RULE15) clamp input taken from a digital input chosen by allocation field
// (RULE16) reach output on general output one by default, reassignable
// (RULE17) rotary maximum velocity setting, default 10000 rpm
// (RULE18) first-order filter per control cycle; comparisons use filtered value
package vcc_pkg;

   // clock and control cycle
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned CTRL_PERIOD_NS = 10000;
   localparam int unsigned CTRL_CYCLES    = CTRL_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned TICK_W         = 10;

   // widths
   localparam int unsigned DATA_W   = 16;
   localparam int unsigned FRAC_W   = 16;
   localparam int unsigned NUM_DIN  = 8;
   localparam int unsigned NUM_DOUT = 4;
   localparam int unsigned ADDR_W   = 8;

   // register byte offsets
   localparam logic [7:0] OFS_FILT_TC    = 8'h00;
   localparam logic [7:0] OFS_CLAMP_ROT  = 8'h04;
   localparam logic [7:0] OFS_CLAMP_LIN  = 8'h08;
   localparam logic [7:0] OFS_REACH_ROT  = 8'h0C;
   localparam logic [7:0] OFS_REACH_LIN  = 8'h10;
   localparam logic [7:0] OFS_MODE       = 8'h14;
   localparam logic [7:0] OFS_CLAMP_PIN  = 8'h18;
   localparam logic [7:0] OFS_REACH_PIN  = 8'h1C;
   localparam logic [7:0] OFS_MOTOR_CFG  = 8'h20;
   localparam logic [7:0] OFS_MAX_VEL    = 8'h24;
   localparam logic [7:0] OFS_STATUS     = 8'h28;
   localparam logic [7:0] OFS_FILT_CMD   = 8'h2C;

   // reset values
   localparam logic [15:0] RST_FILT_TC   = 16'h0028;
   localparam logic [15:0] RST_CLAMP     = 16'h000A;
   localparam logic [15:0] RST_REACH     = 16'h000A;
   localparam logic [15:0] RST_MAX_VEL   = 16'h2710;
   localparam logic [3:0]  RST_MODE      = 4'h0;
   localparam logic [3:0]  RST_CLAMP_PIN = 4'hF;
   localparam logic [3:0]  RST_REACH_PIN = 4'h0;

   // control mode codes
   localparam logic [3:0] MODE_VEL        = 4'h0;
   localparam logic [3:0] MODE_IVEL       = 4'h3;
   localparam logic [3:0] MODE_IVEL_POS   = 4'h4;
   localparam logic [3:0] MODE_IVEL_VEL   = 4'h5;
   localparam logic [3:0] MODE_IVEL_TRQ   = 4'h6;
   localparam logic [3:0] MODE_TRQ_VEL    = 4'h9;
   localparam logic [3:0] MODE_IPOS_VEL   = 4'hC;
   localparam logic [3:0] MODE_IVEL_ALT   = 4'hE;

   // status bits
   typedef struct packed {
      logic pin_level;
      logic reached;
      logic clamped;
   } vcc_status_s;

   typedef enum logic [1:0] {
      FLT_IDLE,
      FLT_DIV,
      FLT_APPLY
   } vcc_flt_e;

endpackage

// >>> src/vcc_top.sv
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module vcc_top
   import vcc_pkg::*;
(
   // clock and reset
   input  wire logic                     clock,
   input  wire logic                     rst,
   // register port
   input  wire logic [ADDR_W-1:0]        reg_addr,
   input  wire logic [31:0]              reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic      [31:0]              reg_rdata,
   // command and feedback, same clock
   input  wire logic signed [DATA_W-1:0] vel_cmd_in,
   input  wire logic signed [DATA_W-1:0] motor_speed,
   // digital pins
   input  wire logic [NUM_DIN-1:0]       din_pins,
   input  wire logic                     control_mode_switch,
   output logic      [NUM_DOUT-1:0]      general_outputs,
   // conditioned command
   output logic signed [DATA_W-1:0]      vel_cmd_out,
   output logic                          hold_position
);

   // absolute value of a 17-bit signed quantity
   function automatic logic [16:0] abs17(input logic signed [16:0] v);
      abs17 = v[16] ? 17'(-v) : 17'(v);
   endfunction

   // clamp allowed only in a velocity-type mode
   function automatic logic vel_mode(input logic [3:0] m, input logic sw);
      unique case (m)
         MODE_VEL, MODE_IVEL, MODE_IVEL_VEL, MODE_IVEL_ALT: vel_mode = 1'b1;
         MODE_IVEL_POS, MODE_IVEL_TRQ: vel_mode = ~sw;
         MODE_TRQ_VEL, MODE_IPOS_VEL: vel_mode = sw;
         default: vel_mode = 1'b0;
      endcase
   endfunction

   // settings
   logic [15:0] filt_tc_q;
   logic [15:0] clamp_rot_q;
   logic [15:0] clamp_lin_q;
   logic [15:0] reach_rot_q;
   logic [15:0] reach_lin_q;
   logic [15:0] max_vel_q;
   logic [3:0]  mode_q;
   logic [3:0]  clamp_pin_q;
   logic [3:0]  reach_pin_q;
   logic        linear_q;

   // pin synchronisers
   logic [NUM_DIN:0] pin_meta_q;
   logic [NUM_DIN:0] pin_sync_q;

   // control tick
   logic [TICK_W-1:0] tick_cnt_q;
   logic              tick_q;

   // filter
   vcc_flt_e             flt_state_q;
   logic signed [32:0]   acc_q;
   logic [31:0]          dq_q;
   logic [17:0]          rem_q;
   logic [5:0]           step_q;
   logic                 neg_q;
   logic signed [DATA_W-1:0] sample_q;

   // outputs and status
   vcc_status_s          status_q;
   logic                 reach_q;

   // combinational helpers
   logic signed [DATA_W-1:0] filt_now;
   logic [16:0]              diff_abs;
   logic [17:0]              rem_shift;
   logic [17:0]              divisor;
   logic [15:0]              lvl_sel;
   logic [15:0]              lvl_eff;
   logic [15:0]              band_sel;
   logic                     clamp_in;
   logic                     clamp_now;
   logic [16:0]              cmd_abs;
   logic [16:0]              err_abs;

   assign filt_now  = acc_q[FRAC_W+DATA_W-1:FRAC_W];
   assign diff_abs  = abs17(17'(vel_cmd_in) - 17'(filt_now));
   assign divisor   = 18'(filt_tc_q) + 18'h00001;
   assign rem_shift = {rem_q[16:0], dq_q[31]};

   // rotary or linear setting chosen by motor type
   assign lvl_sel  = linear_q ? clamp_lin_q : clamp_rot_q; // (RULE7) (RULE8)
   assign band_sel = linear_q ? reach_lin_q : reach_rot_q; // (RULE13) (RULE14)
   assign lvl_eff  = (lvl_sel > max_vel_q) ? max_vel_q : lvl_sel; // (RULE9)

   // unallocated pin codes read as an inactive input
   assign clamp_in = (clamp_pin_q < 4'(NUM_DIN))
                     ? pin_sync_q[3'(clamp_pin_q)] : 1'b0; // (RULE15)

   // comparisons on the filtered command
   assign cmd_abs = abs17(17'(filt_now)); // (RULE18)
   assign err_abs = abs17(17'(motor_speed) - 17'(filt_now));
   assign clamp_now = clamp_in // (RULE5)
                    & vel_mode(mode_q, pin_sync_q[NUM_DIN]) // (RULE6)
                    & (cmd_abs < 17'(lvl_eff)); // (RULE3) (RULE4)

   // register writes; settings take effect on the next control cycle, the reach output allocation on the next clock
   always_ff @(posedge clock) begin
      if (rst) begin
         filt_tc_q   <= RST_FILT_TC; // (RULE1)
         clamp_rot_q <= RST_CLAMP;
         clamp_lin_q <= RST_CLAMP;
         reach_rot_q <= RST_REACH;
         reach_lin_q <= RST_REACH;
         max_vel_q   <= RST_MAX_VEL; // (RULE17)
         mode_q      <= RST_MODE;
         clamp_pin_q <= RST_CLAMP_PIN;
         reach_pin_q <= RST_REACH_PIN; // (RULE16)
         linear_q    <= 1'b0;
      end else if (reg_wr) begin
         unique case (reg_addr)
            OFS_FILT_TC:   filt_tc_q   <= reg_wdata[15:0];
            OFS_CLAMP_ROT: clamp_rot_q <= reg_wdata[15:0];
            OFS_CLAMP_LIN: clamp_lin_q <= reg_wdata[15:0];
            OFS_REACH_ROT: reach_rot_q <= reg_wdata[15:0];
            OFS_REACH_LIN: reach_lin_q <= reg_wdata[15:0];
            OFS_MODE:      mode_q      <= reg_wdata[3:0];
            OFS_CLAMP_PIN: clamp_pin_q <= reg_wdata[3:0];
            OFS_REACH_PIN: reach_pin_q <= reg_wdata[3:0];
            OFS_MOTOR_CFG: linear_q    <= reg_wdata[0];
            OFS_MAX_VEL:   max_vel_q   <= reg_wdata[15:0];
            default: ;
         endcase
      end
   end

   // register reads, data one cycle after the strobe, unmapped reads zero
   always_ff @(posedge clock) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            OFS_FILT_TC:   reg_rdata <= {16'h0000, filt_tc_q};
            OFS_CLAMP_ROT: reg_rdata <= {16'h0000, clamp_rot_q};
            OFS_CLAMP_LIN: reg_rdata <= {16'h0000, clamp_lin_q};
            OFS_REACH_ROT: reg_rdata <= {16'h0000, reach_rot_q};
            OFS_REACH_LIN: reg_rdata <= {16'h0000, reach_lin_q};
            OFS_MODE:      reg_rdata <= {28'h0000000, mode_q};
            OFS_CLAMP_PIN: reg_rdata <= {28'h0000000, clamp_pin_q};
            OFS_REACH_PIN: reg_rdata <= {28'h0000000, reach_pin_q};
            OFS_MOTOR_CFG: reg_rdata <= {31'h00000000, linear_q};
            OFS_MAX_VEL:   reg_rdata <= {16'h0000, max_vel_q};
            OFS_STATUS:    reg_rdata <= {29'h00000000, status_q};
            OFS_FILT_CMD:  reg_rdata <= {{16{filt_now[15]}}, filt_now};
            default:       reg_rdata <= 32'h00000000;
         endcase
      end
   end

   // two-flop synchronisers for pins and the mode switch
   always_ff @(posedge clock) begin
      if (rst) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end else begin
         pin_meta_q <= {control_mode_switch, din_pins};
         pin_sync_q <= pin_meta_q;
      end
   end

   // control cycle divider, one pulse per sample period
   always_ff @(posedge clock) begin
      if (rst) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == TICK_W'(CTRL_CYCLES - 1)) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
         tick_q     <= 1'b0;
      end
   end

   // first-order low pass: acc += (x - acc) / (tc + 1) each cycle;
   // serial division keeps area small, 32 clocks well inside a period
   always_ff @(posedge clock) begin
      if (rst) begin
         flt_state_q <= FLT_IDLE;
         acc_q       <= '0;
         dq_q        <= '0;
         rem_q       <= '0;
         step_q      <= '0;
         neg_q       <= 1'b0;
         sample_q    <= '0;
      end else begin
         unique case (flt_state_q)
            FLT_IDLE: begin
               if (tick_q) begin
                  sample_q <= vel_cmd_in;
                  // signed compare alone picks the step direction
                  neg_q    <= (vel_cmd_in < filt_now);
                  dq_q     <= {diff_abs[15:0], 16'h0000};
                  rem_q    <= '0;
                  step_q   <= '0;
                  flt_state_q <= (filt_tc_q == 16'h0000)
                                 ? FLT_APPLY : FLT_DIV; // (RULE1)
               end
            end
            FLT_DIV: begin
               // larger tc, larger divisor, smaller step (RULE2)
               if (rem_shift >= divisor) begin
                  rem_q <= rem_shift - divisor;
                  dq_q  <= {dq_q[30:0], 1'b1};
               end else begin
                  rem_q <= rem_shift;
                  dq_q  <= {dq_q[30:0], 1'b0};
               end
               step_q <= step_q + 1'b1;
               if (step_q == 6'(FRAC_W + DATA_W - 1)) begin
                  flt_state_q <= FLT_APPLY;
               end
            end
            FLT_APPLY: begin
               if (filt_tc_q == 16'h0000) begin
                  acc_q <= {sample_q[15], sample_q, 16'h0000};
               end else if (neg_q) begin
                  acc_q <= acc_q - 33'(dq_q); // (RULE18)
               end else begin
                  acc_q <= acc_q + 33'(dq_q); // (RULE18)
               end
               flt_state_q <= FLT_IDLE;
            end
            default: flt_state_q <= FLT_IDLE;
         endcase
      end
   end

   // clamp, reach and conditioned command once per control cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         vel_cmd_out   <= '0;
         hold_position <= 1'b0;
         reach_q       <= 1'b0;
         status_q      <= '0;
      end else if (tick_q) begin
         vel_cmd_out   <= clamp_now ? '0 : filt_now; // (RULE3)
         hold_position <= clamp_now; // (RULE3) (RULE4) (RULE5)
         reach_q       <= (err_abs <= 17'(band_sel)); // (RULE10) (RULE11) (RULE12)
         status_q.clamped   <= clamp_now;
         status_q.reached   <= (err_abs <= 17'(band_sel));
         status_q.pin_level <= clamp_in;
      end
   end

   // reach indication steered to the allocated general output
   genvar g;
   generate
      for (g = 0; g < NUM_DOUT; g++) begin : g_dout
         always_ff @(posedge clock) begin
            if (rst) begin
               general_outputs[g] <= 1'b0;
            end else begin
               general_outputs[g] <= reach_q
                  & (reach_pin_q == 4'(g)); // (RULE16)
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// >>> verif/vcc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module vcc_monitor
   import vcc_pkg::*;
(
   // clock and reset
   input wire logic                     clock,
   input wire logic                     rst,
   // register port
   input wire logic [ADDR_W-1:0]        reg_addr,
   input wire logic                     reg_rd,
   input wire logic [31:0]              reg_rdata,
   // conditioned outputs
   input wire logic [NUM_DOUT-1:0]      general_outputs,
   input wire logic signed [DATA_W-1:0] vel_cmd_out,
   input wire logic                     hold_position
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   // outputs stand a whole control period, except general outputs on a reach pin write, so an update is followed by calm
   sequence s_calm(sig);
      ##1 $stable(sig) [*8];
   endsequence
   sequence s_rd_gap;
      reg_rd ##1 1'b1;
   endsequence

   property p_rst_clear;
      $fell(rst) |-> vel_cmd_out == 0 && !hold_position && general_outputs == 0;
   endproperty
   property p_hold_zero;
      hold_position |-> vel_cmd_out == 0;
   endproperty
   property p_hold_calm;
      $changed(hold_position) |-> s_calm(hold_position);
   endproperty
   property p_cmd_calm;
      $changed(vel_cmd_out) |-> s_calm(vel_cmd_out);
   endproperty
   property p_gout_calm;
      $changed(general_outputs) |-> s_calm(general_outputs);
   endproperty
   property p_rd_unmapped;
      reg_rd && reg_addr == 8'h30 |=> reg_rdata == 32'h0;
   endproperty
   property p_rd_upper;
      s_rd_gap |-> reg_rdata[31:16] == 16'h0
         || ($past(reg_addr) == OFS_FILT_CMD
             && reg_rdata[31:16] == {16{reg_rdata[15]}});
   endproperty
   property p_rdata_keep;
      !reg_rd |=> $stable(reg_rdata);
   endproperty

   a_rst_clear: assert property (p_rst_clear) else $error("outputs not clear");
   a_hold_zero: assert property (p_hold_zero)
      else $error("command passed while held");
   a_hold_calm: assert property (p_hold_calm)
      else $error("hold changed mid period");
   a_cmd_calm: assert property (p_cmd_calm)
      else $error("command changed mid period");
   a_gout_calm: assert property (p_gout_calm)
      else $error("outputs changed mid period");
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
   a_rd_upper: assert property (p_rd_upper) else $error("upper bits set");
   a_rdata_keep: assert property (p_rdata_keep) else $error("read data moved");
endmodule
bind vcc_top vcc_monitor u_mon (.clock(clock), .rst(rst),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .general_outputs(general_outputs), .vel_cmd_out(vel_cmd_out),
   .hold_position(hold_position));
`default_nettype wire

// >>> verif/vcc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module vcc_ctrl_model
   import vcc_pkg::*;
(
   // clock
   input  wire logic                clock,
   // toward the block
   output logic signed [DATA_W-1:0] vel_cmd,
   output logic signed [DATA_W-1:0] speed,
   output logic [NUM_DIN-1:0]       din,
   output logic                     mode_sw
);
   initial begin
      vel_cmd = '0;
      speed = '0;
      din = '0;
      mode_sw = 1'b0;
   end

   // controller changes its lines just after an edge; other pins stay low
   task automatic drive(input logic signed [DATA_W-1:0] c, s,
                        input logic zh, sw, input int p);
      @(posedge clock);
      vel_cmd <= c;
      speed <= s;
      din <= NUM_DIN'(zh) << p;
      mode_sw <= sw;
   endtask
endmodule
`default_nettype wire

// >>> verif/velocity_command_conditioning_test.sv
`timescale 1ns/1ps
`default_nettype none
module velocity_command_conditioning_test;
   import vcc_pkg::*;
   typedef struct packed {
      logic [3:0]  mode;
      logic        sw, zh, h, r;
      logic [15:0] c, s;
   } vcc_row_s;
   logic                     clock = 1'b0;
   logic                     rst = 1'b1;
   logic [ADDR_W-1:0]        reg_addr = '0;
   logic [31:0]              reg_wdata = '0;
   logic                     reg_wr = 1'b0;
   logic                     reg_rd = 1'b0;
   logic [31:0]              reg_rdata, rd_q;
   logic signed [DATA_W-1:0] vel_cmd_in, motor_speed, vel_cmd_out;
   logic [NUM_DIN-1:0]       din_pins;
   logic                     control_mode_switch, hold_position;
   logic [NUM_DOUT-1:0]      general_outputs;
   int                       err_count = 0;
   int                       samples_checked = 0;
   // mode, {switch, hold input, hold, reach}, command, speed
   vcc_row_s rows [12] = '{
      {4'h0, 4'b0111, 16'd5, 16'd5}, {4'h0, 4'b0100, 16'd10, 16'd21},
      {4'h0, 4'b0001, 16'hFFFB, 16'd5}, {4'h3, 4'b0111, 16'd3, 16'hFFF9},
      {4'hE, 4'b0111, 16'd3, 16'd3}, {4'h7, 4'b0101, 16'd3, 16'd3},
      {4'h4, 4'b0111, 16'd3, 16'd3}, {4'h4, 4'b1101, 16'd3, 16'd3},
      {4'h9, 4'b1111, 16'd3, 16'd3}, {4'h5, 4'b1111, 16'd3, 16'd3},
      {4'h6, 4'b1101, 16'd3, 16'd3}, {4'hC, 4'b0101, 16'd3, 16'd3}};
   logic [31:0] dflt [10] = '{32'h28, 32'hA, 32'hA, 32'hA, 32'hA, 32'h0,
                              32'hF, 32'h0, 32'h0, 32'h2710};

   vcc_top u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .vel_cmd_in(vel_cmd_in),
      .motor_speed(motor_speed), .din_pins(din_pins),
      .control_mode_switch(control_mode_switch),
      .general_outputs(general_outputs), .vel_cmd_out(vel_cmd_out),
      .hold_position(hold_position));
   vcc_ctrl_model u_ctrl (.clock(clock), .vel_cmd(vel_cmd_in),
      .speed(motor_speed), .din(din_pins), .mode_sw(control_mode_switch));

   always #5 clock = ~clock;

   task automatic chk(input string n, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
      rd_q = reg_rdata;
   endtask
   // two control ticks: one to sample, one to present
   task automatic look(input logic h, r, input logic [15:0] c);
      repeat (2100) @(posedge clock);
      chk("hold_position", {31'h0, h}, {31'h0, hold_position});
      chk("vel_cmd_out", {16'h0, c}, {16'h0, vel_cmd_out});
      chk("reach", {31'h0, r}, {31'h0, general_outputs[0]});
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // watchdog: the whole run needs about 38000 cycles
   initial begin
      repeat (60000) @(posedge clock);
      err_count++;
      finish_test();
   end

   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      wr(OFS_FILT_TC, 32'h0);
      wr(OFS_CLAMP_PIN, 32'h2);
      foreach (rows[i]) begin
         wr(OFS_MODE, {28'h0, rows[i].mode});
         u_ctrl.drive(rows[i].c, rows[i].s, rows[i].zh, rows[i].sw, 2);
         look(rows[i].h, rows[i].r, rows[i].h ? 16'h0 : rows[i].c);
         $display("row %0d done", i);
      end
      // second reset in mid run, then defaults and an unmapped place
      @(posedge clock);
      rst <= 1'b1;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      wr(8'h30, 32'hFFFF);
      for (int k = 0; k < 10; k++) begin
         rd(8'(k * 4));
         chk("default", dflt[k], rd_q);
      end
      rd(8'h30);
      chk("unmapped", 32'h0, rd_q);
      $display("defaults done");
      // clamp level limited by maximum velocity
      wr(OFS_FILT_TC, 32'h0);
      wr(OFS_CLAMP_PIN, 32'h2);
      wr(OFS_MAX_VEL, 32'h4);
      u_ctrl.drive(16'd5, 16'd5, 1'b1, 1'b0, 2);
      look(1'b0, 1'b1, 16'd5);
      // linear settings take over from rotary ones
      wr(OFS_MOTOR_CFG, 32'h1);
      wr(OFS_MAX_VEL, 32'h2710);
      wr(OFS_CLAMP_LIN, 32'h14);
      wr(OFS_REACH_LIN, 32'h0);
      u_ctrl.drive(16'd15, 16'd16, 1'b1, 1'b0, 2);
      look(1'b1, 1'b0, 16'h0);
      rd(OFS_STATUS);
      chk("status", 32'h5, rd_q);
      // clamp input and reach output moved to other pins
      wr(OFS_CLAMP_PIN, 32'h5);
      wr(OFS_REACH_PIN, 32'h3);
      u_ctrl.drive(16'd15, 16'd15, 1'b1, 1'b0, 2);
      look(1'b0, 1'b0, 16'd15);
      chk("general_outputs", 32'h8, {28'h0, general_outputs});
      u_ctrl.drive(16'd15, 16'd15, 1'b1, 1'b0, 5);
      look(1'b1, 1'b0, 16'h0);
      $display("pins done");
      // slow filter: each sample moves a hundredth of the remaining gap
      wr(OFS_FILT_TC, 32'h63);
      u_ctrl.drive(16'd1015, 16'd15, 1'b0, 1'b0, 2);
      for (int n = 0; n < 2100 && vel_cmd_out != 16'd25; n++)
         @(posedge clock);
      chk("filter_first", 32'd25, {16'h0, vel_cmd_out});
      repeat (100) @(posedge clock);
      rd(OFS_FILT_CMD);
      chk("filter_step", 32'd34, rd_q);
      // a negative command must step the filter down, not up
      u_ctrl.drive(16'hFC18, 16'd15, 1'b0, 1'b0, 2);
      for (int n = 0; n < 2100 && vel_cmd_out != 16'd24; n++)
         @(posedge clock);
      chk("filter_down", 32'd24, {16'h0, vel_cmd_out});
      $display("filter done");
      finish_test();
   end
endmodule
`default_nettype wire
